// >>> verilog/icpd_pkg.sv
package icpd_pkg;
  // ---------------------------------------------------------------
  // Source numbering, in vector (polling) order
  // ---------------------------------------------------------------
  localparam int ICPD_NSRC      = 12;
  localparam int ICPD_NLVL      = 4;
  localparam int ICPD_SRC_EXTA  = 0;
  localparam int ICPD_SRC_TMRA  = 1;
  localparam int ICPD_SRC_EXTB  = 2;
  localparam int ICPD_SRC_TMRB  = 3;
  localparam int ICPD_SRC_SER   = 4;
  localparam int ICPD_SRC_TMRC  = 5;
  localparam int ICPD_SRC_CMP   = 6;
  localparam int ICPD_SRC_GP    = 7;
  localparam int ICPD_SRC_CCA   = 8;
  localparam int ICPD_SRC_SPI   = 9;
  localparam int ICPD_SRC_ADC   = 10;
  localparam int ICPD_SRC_TWI   = 11;
  // ---------------------------------------------------------------
  // Vector table
  // ---------------------------------------------------------------
  localparam logic [15:0] ICPD_VEC_RESET = 16'h0000;
  localparam logic [15:0] ICPD_VEC_BASE  = 16'h0003;
  localparam logic [15:0] ICPD_VEC_STEP  = 16'h0008;
  // Level-disable bit position within each priority register
  localparam int ICPD_LVL_DIS_BIT = 7;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int ICPD_CLK_HZ       = 25000000;
  localparam int ICPD_CALL_CYCLES  = 4;
  localparam int ICPD_WAKE_RST_CYC = 2;
  localparam int ICPD_STARTUP_US   = 1000;
  localparam int ICPD_STARTUP_CYC  =
    (ICPD_STARTUP_US * (ICPD_CLK_HZ / 1000000));
  // ---------------------------------------------------------------
  // Power state machine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ICPD_PW_RUN   = 3'b000,
    ICPD_PW_DOWN  = 3'b001,
    ICPD_PW_TIMED = 3'b010,
    ICPD_PW_EXT   = 3'b011,
    ICPD_PW_RSTT  = 3'b100,
    ICPD_PW_RSTH  = 3'b101,
    ICPD_PW_RSTP  = 3'b110
  } icpd_pw_t;
endpackage

// >>> verilog/icpd_prio_pick.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Winner picker: highest level, then lowest index
// ---------------------------------------------------------------
module icpd_prio_pick
  import icpd_pkg::*;
#(
  parameter int N = 12
)
(
  input  wire logic [N-1:0]   req,      // Qualified requests
  input  wire logic [2*N-1:0] lvl,      // Two bits of level per source
  input  wire logic [3:0]     lvl_ok,   // Levels allowed to preempt
  output logic                hit,      // Some request wins
  output logic [3:0]          win_idx,  // Winning source
  output logic [1:0]          win_lvl   // Its level
);
  initial
  begin
    if (N > 16)
      $error("icpd_prio_pick: at most 16 sources");
  end
  // Scan from last to first so the lowest index wins ties
  always_comb
  begin
    hit     = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i] && lvl_ok[lvl[2*i +: 2]] &&
          (!hit || lvl[2*i +: 2] >= win_lvl))
      begin
        hit     = 1'b1;
        win_idx = 4'(i);
        win_lvl = lvl[2*i +: 2];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/icpd_irq_ctrl.sv
// Function
// RL1: twelve sources, own enable plus global enable
// RL2: level from low bit and high bit
// RL3: preempt only by strictly higher level
// RL4: same level: lowest vector wins
// RL5: bit seven disables whole priority level
// RL6: external inputs level or edge typed
// RL7: external flag cleared on vector only edge
// RL8: timer a/b flags cleared on vectoring
// RL9: timer c request ORs two flags
// RL10: serial and spi requests OR flags
// RL11: gp request ORs eight pin flags
// RL12: comparator request ORs two flags
// RL13: conversion flag cleared on vectoring
// RL14: capture request ORs four low bits
// RL15: two-wire flag cleared by software only
// RL16: software set/clear equals hardware set/clear
// RL17: vectors 0003H onward in 8-byte steps
// RL18: wake on enabled level ext or gp
// RL19: exit mode 0: timed start-up wake
// RL20: exit mode 1: wait for pin rise
// RL21: external source holds pin long enough
// RL22: reset pin wake, two-cycle reset pulse
// RL23: vectoring is four-cycle hardware call
// RL24: synchronous sampling, nesting stack freed on return
`timescale 1ns/100ps
`default_nettype none
module icpd_irq_ctrl
  import icpd_pkg::*;
#(
  parameter int STARTUP_CYC = ICPD_STARTUP_CYC  // Start-up timer length
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  // Enables and priorities
  input  wire logic [7:0]  irq_enable_reg,          // Global + 7 enables
  input  wire logic [4:0]  irq_enable_reg_second,   // 5 more enables
  input  wire logic [7:0]  prio_low_reg,
  input  wire logic [7:0]  prio_high_reg,
  input  wire logic [7:0]  prio_low_reg_second,
  input  wire logic [7:0]  prio_high_reg_second,
  input  wire logic        ext_a_type,              // 1 = edge
  input  wire logic        ext_b_type,
  input  wire logic        wake_exit_mode,
  input  wire logic        power_down_req,          // Enter power-down
  // Pins (asynchronous)
  input  wire logic        ext_irq_a_pin_n,
  input  wire logic        ext_irq_b_pin_n,
  input  wire logic        reset_pin_n,
  // External flag software access
  input  wire logic        ext_a_flag_set,
  input  wire logic        ext_a_flag_clr,
  input  wire logic        ext_b_flag_set,
  input  wire logic        ext_b_flag_clr,
  // Peripheral flags (already software-writable at their owners)
  input  wire logic        timer_a_overflow_flag,
  input  wire logic        timer_b_overflow_flag,
  input  wire logic        timer_c_overflow_flag,
  input  wire logic        timer_c_external_flag,
  input  wire logic        serial_rx_flag,
  input  wire logic        serial_tx_flag,
  input  wire logic        spi_done_flag,
  input  wire logic        spi_mode_fault_flag,
  input  wire logic        spi_tx_empty_flag,
  input  wire logic [7:0]  gp_pin_flags,
  input  wire logic [7:0]  gp_pin_enable_mask,
  input  wire logic [7:0]  gp_pin_level_mode,       // 1 = level detect
  input  wire logic        comparator_a_flag,
  input  wire logic        comparator_b_flag,
  input  wire logic        conversion_done_flag,
  input  wire logic [7:0]  capture_channel_flags,
  input  wire logic        two_wire_flag,
  // CPU handshake
  input  wire logic        poll,                    // Last instr cycle
  input  wire logic        block_poll,              // RETI/IE/IP write
  input  wire logic        reti,                    // Return executed
  // Outputs
  output logic             ext_a_flag,
  output logic             ext_b_flag,
  output logic             call_busy,               // Hardware call runs
  output logic [15:0]      vector_addr,
  output logic             timer_a_flag_clr,        // Pulses on vector
  output logic             timer_b_flag_clr,
  output logic             conversion_flag_clr,
  output logic             cpu_clk_en,              // Clock gate to CPU
  output logic             cpu_reset,               // Reset to CPU
  output logic [3:0]       active_levels            // Nesting stack
);
  initial
  begin
    if (STARTUP_CYC < 1)
      $error("icpd_irq_ctrl: STARTUP_CYC must be at least 1");
  end
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_s1_reg;    // First stage, read only by second
  logic [2:0] pin_s2_reg;    // Safe copy
  logic [2:0] pin_d_reg;     // Previous safe copy for edges
  // Two flops before any logic looks at a pin
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_s1_reg <= 3'h7;
      pin_s2_reg <= 3'h7;
      pin_d_reg  <= 3'h7;
    end
    else
    begin
      pin_s1_reg <= {reset_pin_n, ext_irq_b_pin_n, ext_irq_a_pin_n};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end
  wire [2:0] pin_low  = ~pin_s2_reg;
  wire [2:0] pin_fall = pin_d_reg & ~pin_s2_reg;
  wire [2:0] pin_rise = ~pin_d_reg & pin_s2_reg;
  // ---------------------------------------------------------------
  // Request flags and qualification
  // ---------------------------------------------------------------
  logic        ext_a_flag_reg;
  logic        ext_b_flag_reg;
  logic        take;            // A vector is taken this cycle
  logic [3:0]  win_idx;
  logic [1:0]  win_lvl;
  logic        hit;
  wire take_a = take && (win_idx == 4'(ICPD_SRC_EXTA));
  wire take_b = take && (win_idx == 4'(ICPD_SRC_EXTB));
  // Edge mode latches; level mode follows pin; set wins over clear
  wire ext_a_next = ext_a_type ?                                 // [RL6]
    ((ext_a_flag_reg && !ext_a_flag_clr && !take_a) ||          // [RL7]
     pin_fall[0] || ext_a_flag_set) :                           // [RL16]
    (pin_low[0] || ext_a_flag_set);
  wire ext_b_next = ext_b_type ?                                 // [RL6]
    ((ext_b_flag_reg && !ext_b_flag_clr && !take_b) ||          // [RL7]
     pin_fall[1] || ext_b_flag_set) :                           // [RL16]
    (pin_low[1] || ext_b_flag_set);
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ext_a_flag_reg <= 1'b0;
      ext_b_flag_reg <= 1'b0;
    end
    else
    begin
      ext_a_flag_reg <= ext_a_next;
      ext_b_flag_reg <= ext_b_next;
    end
  end
  // Raw requests in vector order
  logic [ICPD_NSRC-1:0] raw_req;
  always_comb
  begin
    raw_req = '0;
    raw_req[ICPD_SRC_EXTA] = ext_a_flag_reg;
    raw_req[ICPD_SRC_TMRA] = timer_a_overflow_flag;                // [RL8]
    raw_req[ICPD_SRC_EXTB] = ext_b_flag_reg;
    raw_req[ICPD_SRC_TMRB] = timer_b_overflow_flag;                // [RL8]
    raw_req[ICPD_SRC_SER]  = serial_rx_flag | serial_tx_flag;      // [RL10]
    raw_req[ICPD_SRC_TMRC] = timer_c_overflow_flag |
                             timer_c_external_flag;                // [RL9]
    raw_req[ICPD_SRC_CMP]  = comparator_a_flag | comparator_b_flag; // [RL12]
    raw_req[ICPD_SRC_GP]   = |gp_pin_flags;                        // [RL11]
    raw_req[ICPD_SRC_CCA]  = |capture_channel_flags[3:0];          // [RL14]
    raw_req[ICPD_SRC_SPI]  = spi_done_flag | spi_mode_fault_flag |
                             spi_tx_empty_flag;                    // [RL10]
    raw_req[ICPD_SRC_ADC]  = conversion_done_flag;                 // [RL13]
    raw_req[ICPD_SRC_TWI]  = two_wire_flag;                        // [RL15]
  end
  // Registered sample: polling sees the previous cycle's values
  logic [ICPD_NSRC-1:0] req_reg;
  always_ff @(posedge clk)
  begin
    if (srst)
      req_reg <= '0;
    else
      req_reg <= raw_req;                                          // [RL24]
  end
  // Enable vector in source order
  wire [ICPD_NSRC-1:0] src_en =
    {irq_enable_reg_second, irq_enable_reg[6:0]};
  wire global_irq_enable = irq_enable_reg[7];
  wire [ICPD_NSRC-1:0] qual_req =
    req_reg & src_en & {ICPD_NSRC{global_irq_enable}};             // [RL1]
  // Level per source: low bits from first pair for 0..6, second 7..11
  logic [2*ICPD_NSRC-1:0] src_lvl;
  genvar g;
  generate
    for (g = 0; g < ICPD_NSRC; g++)
    begin : g_lvl
      if (g < 7)
      begin : g_first
        assign src_lvl[2*g +: 2] = {prio_high_reg[g], prio_low_reg[g]};
      end
      else
      begin : g_second
        assign src_lvl[2*g +: 2] =
          {prio_high_reg_second[g-7], prio_low_reg_second[g-7]}; // [RL2]
      end
    end
  endgenerate
  // A level may win only if it is not disabled and is above all active
  wire [3:0] lvl_dis = {prio_high_reg_second[ICPD_LVL_DIS_BIT],
                        prio_low_reg_second[ICPD_LVL_DIS_BIT],
                        prio_high_reg[ICPD_LVL_DIS_BIT],
                        prio_low_reg[ICPD_LVL_DIS_BIT]};           // [RL5]
  logic [3:0] active_reg;
  logic [3:0] above_active;
  always_comb
  begin
    above_active = 4'hf;
    for (int l = 0; l < ICPD_NLVL; l++)
      if (active_reg[l])
        above_active = 4'hf << (l + 1);                           // [RL3]
  end
  wire [3:0] lvl_ok = above_active & ~lvl_dis;
  icpd_prio_pick #(
    .N (ICPD_NSRC)
  ) u_pick (
    .req     (qual_req),
    .lvl     (src_lvl),
    .lvl_ok  (lvl_ok),
    .hit     (hit),                                               // [RL4]
    .win_idx (win_idx),
    .win_lvl (win_lvl)
  );
  // ---------------------------------------------------------------
  // Vectoring call and nesting stack
  // ---------------------------------------------------------------
  logic [2:0]  call_cnt_reg;
  logic [15:0] vector_reg;
  logic [2:0]  hwclr_reg;
  logic        busy_reg;     // Call in progress, straight from a flop
  wire cpu_run = (cpu_clk_en && !cpu_reset);
  assign take = poll && !block_poll && hit && (call_cnt_reg == 3'h0)
                && cpu_run;
  // Highest active level is the one freed on return
  logic [3:0] top_active;
  always_comb
  begin
    top_active = 4'h0;
    for (int l = 0; l < ICPD_NLVL; l++)
      if (active_reg[l])
        top_active = 4'h1 << l;
  end
  wire [15:0] vec_next = ICPD_VEC_BASE +
    16'(ICPD_VEC_STEP * {12'h000, win_idx});                       // [RL17]
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      call_cnt_reg <= 3'h0;
      vector_reg   <= ICPD_VEC_RESET;
      active_reg   <= 4'h0;
      hwclr_reg    <= 3'h0;
      busy_reg     <= 1'b0;
    end
    else
    begin
      hwclr_reg <= 3'h0;
      // Mirrors the counter being non-zero after this edge
      busy_reg  <= take || (call_cnt_reg > 3'h1);                // [RL23]
      if (take)
      begin
        call_cnt_reg <= 3'(ICPD_CALL_CYCLES);                    // [RL23]
        vector_reg   <= vec_next;
        active_reg   <= active_reg | (4'h1 << win_lvl);          // [RL24]
        hwclr_reg    <= {win_idx == 4'(ICPD_SRC_ADC),
                         win_idx == 4'(ICPD_SRC_TMRB),
                         win_idx == 4'(ICPD_SRC_TMRA)};          // [RL8]
      end
      else
      begin
        if (call_cnt_reg != 3'h0)
          call_cnt_reg <= call_cnt_reg - 3'h1;                   // [RL23]
        if (reti)
          active_reg <= active_reg & ~top_active;                // [RL24]
      end
    end
  end
  // ---------------------------------------------------------------
  // Power-down wake-up sequencer
  // ---------------------------------------------------------------
  icpd_pw_t    pw_reg;
  icpd_pw_t    pw_next;
  logic [31:0] tmr_reg;
  logic [31:0] tmr_next;
  logic        clk_en_reg;
  logic        cpu_rst_reg;
  // Besides the reset pin, only enabled level-mode sources may end power-down
  wire wake_a  = irq_enable_reg[0] && !ext_a_type && pin_fall[0];
  wire wake_b  = irq_enable_reg[2] && !ext_b_type && pin_fall[1];
  wire gp_wake = irq_enable_reg_second[0] &&
    |(gp_pin_flags & gp_pin_enable_mask & gp_pin_level_mode);
  wire wake_irq = wake_a || wake_b || gp_wake;                     // [RL18]
  wire wake_pin_hi = (wake_a || !pin_low[1]) && (wake_b || !pin_low[0]);
  wire tmr_done = (tmr_reg == 32'(STARTUP_CYC - 1));
  always_comb
  begin
    pw_next  = pw_reg;
    tmr_next = tmr_reg + 32'h1;
    case (pw_reg)
      ICPD_PW_RUN:
      begin
        tmr_next = 32'h0;
        if (power_down_req)
          pw_next = ICPD_PW_DOWN;
      end
      ICPD_PW_DOWN:
      begin
        tmr_next = 32'h0;
        if (pin_fall[2])
          pw_next = ICPD_PW_RSTT;                                 // [RL22]
        else if (wake_irq)
          pw_next = wake_exit_mode ? ICPD_PW_EXT : ICPD_PW_TIMED; // [RL19]
      end
      // Pin need not stay low while timing
      ICPD_PW_TIMED:
        if (tmr_done)
          pw_next = ICPD_PW_RUN;                                  // [RL19]
      // Wait for release of the waking pin; stabilising is on it
      ICPD_PW_EXT:
        if (pin_rise[0] || pin_rise[1] ||
            (gp_wake == 1'b0 && pin_low[1:0] == 2'b00 && wake_pin_hi))
          pw_next = ICPD_PW_RUN;                                  // [RL20]
      ICPD_PW_RSTT:
        if (tmr_done)
          pw_next = pin_low[2] ? ICPD_PW_RSTH : ICPD_PW_RSTP;    // [RL22]
      ICPD_PW_RSTH:
      begin
        tmr_next = 32'h0;
        if (!pin_low[2])
          pw_next = ICPD_PW_RUN;
      end
      ICPD_PW_RSTP:
        if (tmr_reg == 32'(ICPD_WAKE_RST_CYC - 1))
          pw_next = ICPD_PW_RUN;                                  // [RL22]
      default:
        pw_next = ICPD_PW_RUN;
    endcase
    if (pw_next != pw_reg)
      tmr_next = 32'h0;
  end
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pw_reg      <= ICPD_PW_RUN;
      tmr_reg     <= 32'h0;
      clk_en_reg  <= 1'b1;
      cpu_rst_reg <= 1'b0;
    end
    else
    begin
      pw_reg      <= pw_next;
      tmr_reg     <= tmr_next;
      clk_en_reg  <= (pw_next == ICPD_PW_RUN) ||
                     (pw_next == ICPD_PW_RSTP);
      cpu_rst_reg <= (pw_next == ICPD_PW_RSTH) ||
                     (pw_next == ICPD_PW_RSTP);
    end
  end
  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  assign ext_a_flag          = ext_a_flag_reg;
  assign ext_b_flag          = ext_b_flag_reg;
  assign call_busy           = busy_reg;
  assign vector_addr         = vector_reg;
  assign timer_a_flag_clr    = hwclr_reg[0];
  assign timer_b_flag_clr    = hwclr_reg[1];
  assign conversion_flag_clr = hwclr_reg[2];
  assign cpu_clk_en          = clk_en_reg;
  assign cpu_reset           = cpu_rst_reg;
  assign active_levels       = active_reg;
endmodule
`default_nettype wire

// >>> tb/icpd_irq_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Port-level checks
// ---------------------------------------------------------------
module icpd_irq_ctrl_checker
  import icpd_pkg::*;
#(
  parameter int STARTUP_CYC = 8  // Start-up timer length
)
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [7:0]  irq_enable_reg,
  input wire logic        wake_exit_mode,
  input wire logic        call_busy,
  input wire logic [15:0] vector_addr,
  input wire logic        timer_a_flag_clr,
  input wire logic        timer_b_flag_clr,
  input wire logic        conversion_flag_clr,
  input wire logic        cpu_clk_en
);
  logic [15:0] off_cnt;  // Cycles with the CPU clock withheld
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  // Gate-off length; wraps on long sleeps
  always_ff @(posedge clk)
  begin
    if (srst || cpu_clk_en)
      off_cnt <= 16'h0000;
    else
      off_cnt <= off_cnt + 16'h0001;
  end
  property p_call_len;
    $rose(call_busy) |-> call_busy [*4] ##1 !call_busy;
  endproperty
  a_call_len: assert property (p_call_len)
    else $error("bad call length");
  property p_tmra_clr;
    timer_a_flag_clr |-> ($rose(call_busy) && vector_addr == 16'h000b)
      ##1 !timer_a_flag_clr;
  endproperty
  a_tmra_clr: assert property (p_tmra_clr)
    else $error("timer a clear");
  property p_tmrb_clr;
    timer_b_flag_clr |-> ($rose(call_busy) && vector_addr == 16'h001b)
      ##1 !timer_b_flag_clr;
  endproperty
  a_tmrb_clr: assert property (p_tmrb_clr)
    else $error("timer b clear");
  property p_adc_clr;
    conversion_flag_clr |-> ($rose(call_busy) && vector_addr == 16'h0053)
      ##1 !conversion_flag_clr;
  endproperty
  a_adc_clr: assert property (p_adc_clr)
    else $error("conversion clear");
  property p_vec_hold;
    !$rose(call_busy) |-> $stable(vector_addr);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector moved");
  property p_vec_table;
    $rose(call_busy) |-> vector_addr[2:0] == 3'h3
      && vector_addr <= 16'h005b;
  endproperty
  a_vec_table: assert property (p_vec_table)
    else $error("bad vector");
  property p_global_off;
    !irq_enable_reg[7] [*3] |-> !$rose(call_busy);
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("call while disabled");
  property p_timed_wake;
    $rose(cpu_clk_en) && !wake_exit_mode |-> off_cnt >= 16'(STARTUP_CYC);
  endproperty
  a_timed_wake: assert property (p_timed_wake)
    else $error("early clock");
endmodule
bind icpd_irq_ctrl icpd_irq_ctrl_checker #(.STARTUP_CYC(STARTUP_CYC)) chk_u (
  .clk(clk), .srst(srst), .irq_enable_reg(irq_enable_reg),
  .wake_exit_mode(wake_exit_mode), .call_busy(call_busy),
  .vector_addr(vector_addr), .timer_a_flag_clr(timer_a_flag_clr),
  .timer_b_flag_clr(timer_b_flag_clr),
  .conversion_flag_clr(conversion_flag_clr), .cpu_clk_en(cpu_clk_en)
);
`default_nettype wire

// >>> tb/icpd_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// CPU core stand-in: two-cycle instructions
// ---------------------------------------------------------------
module icpd_cpu_model
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic cpu_clk_en,  // No clock, no instructions
  input  wire logic cpu_reset,
  input  wire logic call_busy,
  input  wire logic reti_req,    // Bench asks for a return
  output logic      poll,
  output logic      block_poll,
  output logic      reti
);
  // Every second cycle polls; a return blocks it
  always_ff @(posedge clk)
  begin
    if (srst || !cpu_clk_en || cpu_reset)
    begin
      poll       <= 1'b0;
      block_poll <= 1'b0;
      reti       <= 1'b0;
    end
    else
    begin
      poll       <= !poll && !call_busy;
      block_poll <= reti_req;
      reti       <= reti_req;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
  import icpd_pkg::*;
;
  localparam int SC = 8;  // Short start-up
  // Source number of pf bits 0 to 24
  localparam byte SRC [25] = '{1, 3, 4, 4, 5, 5, 6, 6, 10, 11, 9, 9, 9,
    7, 7, 7, 7, 7, 7, 7, 7, 8, 8, 8, 8};
  logic        clk = 1'b0;
  logic        srst;
  logic [7:0]  ie, pl, ph, pl2, ph2, gpm, gpl;
  logic [4:0]  ie2;
  logic [3:0]  ctl;    // Types, exit mode, power-down
  logic [2:0]  pin_n;  // Ext a, ext b, reset pins
  logic [3:0]  sw;     // Ext flag set/clear pulses
  logic [28:0] pf;     // Peripheral flags
  logic        reti_req, poll, blk, reti;
  logic        fa, fb, busy, clra, clrb, clrc, cke, crst;
  logic [15:0] vec;
  logic [3:0]  act;
  int          fails = 0;
  int          comparisons = 0;
  always #20 clk = ~clk;
  icpd_irq_ctrl #(.STARTUP_CYC(SC)) dut_u (
    .clk(clk), .srst(srst), .irq_enable_reg(ie),
    .irq_enable_reg_second(ie2), .prio_low_reg(pl), .prio_high_reg(ph),
    .prio_low_reg_second(pl2), .prio_high_reg_second(ph2),
    .ext_a_type(ctl[0]), .ext_b_type(ctl[1]), .wake_exit_mode(ctl[2]),
    .power_down_req(ctl[3]), .ext_irq_a_pin_n(pin_n[0]),
    .ext_irq_b_pin_n(pin_n[1]), .reset_pin_n(pin_n[2]),
    .ext_a_flag_set(sw[0]), .ext_a_flag_clr(sw[1]),
    .ext_b_flag_set(sw[2]), .ext_b_flag_clr(sw[3]),
    .timer_a_overflow_flag(pf[0]), .timer_b_overflow_flag(pf[1]),
    .serial_rx_flag(pf[2]), .serial_tx_flag(pf[3]),
    .timer_c_overflow_flag(pf[4]), .timer_c_external_flag(pf[5]),
    .comparator_a_flag(pf[6]), .comparator_b_flag(pf[7]),
    .conversion_done_flag(pf[8]), .two_wire_flag(pf[9]),
    .spi_done_flag(pf[10]), .spi_mode_fault_flag(pf[11]),
    .spi_tx_empty_flag(pf[12]), .gp_pin_flags(pf[20:13]),
    .gp_pin_enable_mask(gpm), .gp_pin_level_mode(gpl),
    .capture_channel_flags(pf[28:21]), .poll(poll), .block_poll(blk),
    .reti(reti), .ext_a_flag(fa), .ext_b_flag(fb), .call_busy(busy),
    .vector_addr(vec), .timer_a_flag_clr(clra), .timer_b_flag_clr(clrb),
    .conversion_flag_clr(clrc), .cpu_clk_en(cke), .cpu_reset(crst),
    .active_levels(act)
  );
  icpd_cpu_model cpu_u (
    .clk(clk), .srst(srst), .cpu_clk_en(cke), .cpu_reset(crst),
    .call_busy(busy), .reti_req(reti_req), .poll(poll),
    .block_poll(blk), .reti(reti)
  );
  // Peripherals drop flags on clear pulses
  always @(posedge clk)
  begin
    if (clra)
      pf[0] <= 1'b0;
    if (clrb)
      pf[1] <= 1'b0;
    if (clrc)
      pf[8] <= 1'b0;
  end
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst_all(input int n);
    srst = 1'b1;
    {ie, ie2, pl, ph, pl2, ph2} = {8'hff, 5'h1f, 32'h0};
    {ctl, pin_n, sw, pf} = {4'h3, 3'h7, 4'h0, 29'h0};
    {gpm, gpl, reti_req} = {8'hff, 8'h00, 1'b0};
    tick(n);
    srst = 1'b0;
    tick(3);
  endtask
  // Wait for a call, then skip its busy cycles
  task automatic take(input logic [15:0] v);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 40)
    begin
      tick(1);
      n++;
    end
    check("vector_addr", vec, v);
    tick(5);
  endtask
  task automatic none(input string nm);
    int n;
    n = 0;
    repeat (30)
    begin
      tick(1);
      n += int'(busy === 1'b1);
    end
    check(nm, 16'(n), 16'h0000);
  endtask
  task automatic ret;
    reti_req = 1'b1;
    tick(1);
    reti_req = 1'b0;
    tick(3);
  endtask
  task automatic pd;
    ctl[3] = 1'b1;
    tick(1);
    ctl[3] = 1'b0;
    tick(4);
  endtask
  task automatic wait_clk(output int n);
    n = 0;
    while (cke !== 1'b1 && n < 60)
    begin
      tick(1);
      n++;
    end
  endtask
  // Each flag alone: vector and clearing
  task automatic t_sources;
    int s;
    for (int b = -2; b < 25; b++)
    begin
      s = (b < 0) ? 2 * (b + 2) : int'(SRC[b]);
      if (b < 0)
        sw[s] = 1'b1;
      else
        pf[b] = 1'b1;
      tick(1);
      sw = 4'h0;
      take(16'h0003 + 16'(8 * s));
      if (b < 0)
        check("ext_flag", 16'(fa | fb), 16'h0000);
      else
        check("flag", 16'(pf[b]), 16'(b != 0 && b != 1 && b != 8));
      pf = 29'h0;
      ret();
    end
  endtask
  task automatic t_global;
    pf[0] = 1'b1;
    ie = 8'h7f;
    none("global_off");
    ie = 8'hfd;
    none("own_off");
    ie = 8'hff;
    take(16'h000b);
    ret();
    pf[28:25] = 4'hf;
    none("capture_high");
    pf = 29'h0;
    ie = 8'h7f;
    sw = 4'h1;
    tick(1);
    sw = 4'h2;
    check("sw_set", 16'(fa), 16'h0001);
    tick(1);
    sw = 4'h0;
    tick(1);
    check("sw_clr", 16'(fa), 16'h0000);
    ie = 8'hff;
    none("cancelled");
  endtask
  task automatic t_prio;
    pf[2:1] = 2'h3;
    take(16'h001b);
    none("same_level");
    ret();
    take(16'h0023);
    pf = 29'h0;
    ret();
    pl[5:3] = 3'h7;
    ph[5:4] = 2'h3;
    pf[0] = 1'b1;
    take(16'h000b);
    pf[1] = 1'b1;
    take(16'h001b);
    pf[2] = 1'b1;
    take(16'h0023);
    pf[4] = 1'b1;
    none("top_level");
    check("levels", 16'(act), 16'h000b);
    pf = 29'h0;
    repeat (3) ret();
    check("levels", 16'(act), 16'h0000);
    ph2[7] = 1'b1;
    pf[2] = 1'b1;
    none("level_off");
    pf = 29'h0;
  endtask
  task automatic t_wake;
    int n;
    ctl = 4'h0;
    pd();
    check("clk_off", 16'(cke), 16'h0000);
    pin_n[0] = 1'b0;
    tick(3);
    pin_n[0] = 1'b1;
    wait_clk(n);
    check("timed", 16'(n >= SC - 3 && n <= SC + 8), 16'h0001);
    ctl = 4'h4;
    pd();
    pin_n[0] = 1'b0;
    tick(20); // Held low to settle
    check("ext_hold", 16'(cke), 16'h0000);
    pin_n[0] = 1'b1;
    wait_clk(n);
    check("ext_rise", 16'(n <= 8), 16'h0001);
    ctl = 4'h1;
    pd();
    pin_n[0] = 1'b0;
    tick(3);
    pin_n[0] = 1'b1;
    tick(20);
    check("edge_no_wake", 16'(cke), 16'h0000);
    {gpm, gpl} = {8'h04, 8'h04};
    pf[15] = 1'b1;
    wait_clk(n);
    check("gp_wake", 16'(n <= SC + 8), 16'h0001);
  endtask
  task automatic t_rstpin;
    int n;
    pd();
    pin_n[2] = 1'b0;
    tick(2);
    pin_n[2] = 1'b1;
    n = 0;
    repeat (40)
    begin
      tick(1);
      n += int'(crst === 1'b1);
    end
    check("short_reset", 16'(n), 16'h0002);
    pd();
    pin_n[2] = 1'b0;
    tick(30);
    check("held_reset", 16'(crst), 16'h0001);
    pin_n[2] = 1'b1;
    tick(8);
    check("reset_gone", 16'(crst), 16'h0000);
  endtask
  initial
  begin
    rst_all(16);
    t_sources();
    t_global();
    t_prio();
    rst_all(2);
    t_wake();
    rst_all(2);
    t_rstpin();
    complete_run();
  end
  // Watchdog, far past the test length
  initial
  begin
    #(40 * 20000);
    fails++;
    complete_run();
  end
endmodule
`default_nettype wire
